// [inc/lcfg_pkg.sv]
package lcfg_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_DISP   = 8'h00;
   localparam logic [7:0] OFS_PUMP   = 8'h04;
   localparam logic [7:0] OFS_ADDR   = 8'h08;
   localparam logic [7:0] OFS_FRAME  = 8'h0C;
   localparam logic [7:0] OFS_OTP    = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_LINE   = 8'h18;
   // field positions, display register
   localparam int DISP_ON_BIT   = 0;
   localparam int INV_BIT       = 1;
   localparam int ALLPIX_BIT    = 2;
   localparam int VFLIP_BIT     = 3;
   localparam int BRFLIP_BIT    = 4;
   localparam int ORDER_BIT     = 5;
   localparam int VADDR_BIT     = 6;
   localparam int CLKEXT_BIT    = 7;
   localparam int TCOMP_BIT     = 8;
   localparam int GBW_BIT       = 9;
   // pump register
   localparam int PUMP_ON_BIT   = 0;
   localparam int PUMP_MUL_LSB  = 4;
   // address register
   localparam int COL_LSB       = 0;
   localparam int BANK_LSB      = 8;
   // frame register
   localparam int DIV_LSB       = 0;
   localparam int TUNE_LSB      = 4;
   // otp register
   localparam int CALIB_BIT     = 0;
   localparam int OVAPPLY_BIT   = 1;
   localparam int DEFSEL_BIT    = 2;
   localparam int PROG_BIT      = 3;
   // line register
   localparam int NLINE_LSB     = 0;
   localparam int SFINV_BIT     = 7;
   // reset values
   localparam logic       RST_DISP_ON = 1'b0;
   localparam logic       RST_INV     = 1'b0;
   localparam logic       RST_ALLPIX  = 1'b1;
   localparam logic       RST_TCOMP   = 1'b1;
   localparam logic [1:0] RST_PUMPMUL = 2'h0;
   localparam logic [6:0] RST_NLINE   = 7'b0001101;
   localparam logic [2:0] RST_DIV     = 3'b001;
   localparam logic [2:0] RST_TUNE    = 3'b110;
   // oscillator figures
   localparam int OSC_BASE_KHZ  = 400;
   localparam int TUNE_STEP_PCT = 4;
   // display mode
   typedef enum logic [2:0] {
      MODE_OFF, MODE_PDOWN, MODE_NORMAL, MODE_INVERSE, MODE_ALLON
   } lcfg_mode_e;
   // maker field set
   typedef struct packed {
      logic [1:0] pump_mul;
      logic [6:0] nline;
      logic       sfinv;
      logic [2:0] div;
      logic [2:0] tune;
   } lcfg_maker_s;
   // power outputs
   typedef struct packed {
      logic rows_gnd;
      logic osc_run;
      logic hv_on;
   } lcfg_power_s;
   // division ratio for a code
   function automatic logic [13:0] lcfg_ratio(input logic [2:0] code);
      case (code)
         3'd0:    lcfg_ratio = 14'd2448;
         3'd1:    lcfg_ratio = 14'd3265;
         3'd2:    lcfg_ratio = 14'd4082;
         3'd3:    lcfg_ratio = 14'd4896;
         3'd4:    lcfg_ratio = 14'd5714;
         3'd5:    lcfg_ratio = 14'd7340;
         3'd6:    lcfg_ratio = 14'd8968;
         default: lcfg_ratio = 14'd11428;
      endcase
   endfunction
endpackage

// [src/lcfg_mode_dec.sv]
`timescale 1ns/100ps
module lcfg_mode_dec
   import lcfg_pkg::*;
(
   input  wire logic        disp_on_i,  // display enable
   input  wire logic        allpix_i,   // all pixels force
   input  wire logic        inv_i,      // inverse video
   output lcfg_mode_e       mode_o,     // decoded mode
   output lcfg_power_s      power_o     // power controls
);
   // mode and power decode
   always_comb begin
      mode_o  = MODE_NORMAL;
      power_o = '{rows_gnd: 1'b0, osc_run: 1'b1, hv_on: 1'b1};
      if (!disp_on_i && !allpix_i) begin
         mode_o  = MODE_OFF;
         power_o = '{rows_gnd: 1'b1, osc_run: 1'b1, hv_on: 1'b1};
      end else if (!disp_on_i) begin
         mode_o  = MODE_PDOWN;
         power_o = '{rows_gnd: 1'b1, osc_run: 1'b0, hv_on: 1'b0};
      end else if (allpix_i) begin
         mode_o  = MODE_ALLON;
      end else if (inv_i) begin
         mode_o  = MODE_INVERSE;
      end
   end
endmodule

// [src/lcfg_frame_div.sv]
`timescale 1ns/100ps
module lcfg_frame_div
   import lcfg_pkg::*;
(
   input  wire logic        clk_i,      // system clock
   input  wire logic        rst_i,      // async reset high
   input  wire logic        osc_tick_i, // oscillator enable pulse
   input  wire logic [2:0]  div_i,      // divider code
   output logic             frame_o,    // frame pulse
   output logic [2:0]       div_act_o   // code in use
);
   logic [13:0] cnt;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt       <= 14'h0000;
         div_act_o <= RST_DIV;
         frame_o   <= 1'b0;
      end else begin
         frame_o <= 1'b0;
         if (osc_tick_i) begin
            if (cnt == 14'h0000) begin
               cnt       <= lcfg_ratio(div_i) - 14'd1;
               div_act_o <= div_i;
               frame_o   <= 1'b1;
            end else begin
               cnt <= cnt - 14'd1;
            end
         end
      end
   end
endmodule

// [src/lcfg_top.sv]
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
module lcfg_top
   import lcfg_pkg::*;
#(
   parameter int CLK_KHZ = 10000            // system clock rate
)(
   input  wire logic        CLK_SYS_I,      // system clock
   input  wire logic        SYS_RST_I,      // async reset high
   input  wire logic        HARD_CLEAR_N_I, // reset pin, active low
   input  wire logic        OTP_LOCKED_FLAG_I,  // otp_locked_flag bit
   input  wire logic        OTP_FACTORY_LOCK_I, // factory lock bit
   input  wire logic [15:0] OTP_MAKER_I,    // otp maker fields
   input  wire logic [1:0]  HTRANS_I,       // ahb transfer type
   input  wire logic        HSEL_I,         // ahb select
   input  wire logic [31:0] HADDR_I,        // ahb address
   input  wire logic        HWRITE_I,       // ahb write
   input  wire logic [2:0]  HSIZE_I,        // ahb size
   input  wire logic [31:0] HWDATA_I,       // ahb write data
   input  wire logic        HREADY_I,       // ahb ready in
   output logic [31:0]      HRDATA_O,       // ahb read data
   output logic             HREADYOUT_O,    // ahb ready out
   output logic             HRESP_O,        // ahb response
   output lcfg_mode_e       MODE_O,         // display mode
   output lcfg_power_s      POWER_O,        // power controls
   output logic             RAM_WR_OK_O,    // ram writes allowed
   output logic             OTP_PROG_EN_O,  // otp programming allowed
   output logic             FRAME_O,        // frame pulse
   output logic [1:0]       PUMP_MUL_O,     // pump multiplier code
   output logic [2:0]       PUMP_FACTOR_O,  // multiplier value 4..7
   output logic             CHARGE_PUMP_ON_O, // pump enable
   output logic             RAM_BIT_ORDER_SWAP_O, // msb/lsb swap
   output logic             VADDR_O,        // vertical addressing
   output logic             VERTICAL_FLIP_O,  // vertical mirror
   output logic             BOTTOM_ROW_FLIP_O, // bottom row mirror
   output logic             CLOCK_SOURCE_EXT_O, // external clock
   output logic             TEMP_COMP_ON_O, // temperature comp
   output logic             OTP_VOLTAGE_APPLY_O, // otp offset on
   output logic             GREYSCALE_BW_SELECT_O, // b/w mode
   output logic [6:0]       COL_ADDR_O,     // column address
   output logic [4:0]       BANK_ADDR_O,    // bank address
   output logic [6:0]       LINE_INVERSION_COUNT_O, // n-line count
   output logic             SUPERFRAME_INVERT_O, // superframe inv
   output logic [2:0]       TUNE_O,         // tune in use
   output logic [15:0]      OSC_KHZ_O       // nominal osc rate
);
   // pin sync and combined reset
   logic [2:0] pin_sync;
   logic       clear_req;
   logic       rst;
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         pin_sync <= 3'b111;
      end else begin
         pin_sync <= {pin_sync[1:0], HARD_CLEAR_N_I};
      end
   end
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         clear_req <= 1'b0;
      end else if (pin_sync[2] == pin_sync[1]) begin
         clear_req <= ~pin_sync[1];
      end
   end
   // clear_req comes from a flop, so the combined async reset is glitch free
   assign rst = SYS_RST_I | clear_req;

   // bus address phase capture
   logic       ph_wr;
   logic       ph_rd;
   logic [7:0] ph_addr;
   logic       acc;
   assign acc = HSEL_I & HTRANS_I[1] & HREADY_I;
   always_ff @(posedge CLK_SYS_I or posedge rst) begin
      if (rst) begin
         ph_wr   <= 1'b0;
         ph_rd   <= 1'b0;
         ph_addr <= 8'h00;
      end else begin
         ph_wr   <= acc & HWRITE_I;
         ph_rd   <= acc & ~HWRITE_I;
         ph_addr <= HADDR_I[7:0];
      end
   end
   // one wait state on reads, so a write landing at the
   // read's address edge is already visible in the mux
   assign HREADYOUT_O = ~ph_rd;
   assign HRESP_O     = 1'b0;

   // configuration storage
   logic disp_on, inv, allpix;
   logic calib, prog_req;
   lcfg_maker_s host_mk;
   lcfg_maker_s use_mk;
   logic sealed, flock;
   assign sealed = OTP_LOCKED_FLAG_I;
   assign flock  = OTP_FACTORY_LOCK_I;

   // display register
   always_ff @(posedge CLK_SYS_I or posedge rst) begin
      if (rst) begin
         disp_on               <= RST_DISP_ON;
         inv                   <= RST_INV;
         allpix                <= RST_ALLPIX;
         VERTICAL_FLIP_O       <= 1'b0;
         BOTTOM_ROW_FLIP_O     <= 1'b0;
         RAM_BIT_ORDER_SWAP_O  <= 1'b0;
         VADDR_O               <= 1'b0;
         CLOCK_SOURCE_EXT_O    <= 1'b0;
         TEMP_COMP_ON_O        <= RST_TCOMP;
         GREYSCALE_BW_SELECT_O <= 1'b0;
      end else if (ph_wr && ph_addr == OFS_DISP) begin
         disp_on               <= HWDATA_I[DISP_ON_BIT];
         inv                   <= HWDATA_I[INV_BIT];
         allpix                <= HWDATA_I[ALLPIX_BIT];
         VERTICAL_FLIP_O       <= HWDATA_I[VFLIP_BIT];
         BOTTOM_ROW_FLIP_O     <= HWDATA_I[BRFLIP_BIT];
         RAM_BIT_ORDER_SWAP_O  <= HWDATA_I[ORDER_BIT];
         VADDR_O               <= HWDATA_I[VADDR_BIT];
         CLOCK_SOURCE_EXT_O    <= HWDATA_I[CLKEXT_BIT];
         TEMP_COMP_ON_O        <= HWDATA_I[TCOMP_BIT];
         GREYSCALE_BW_SELECT_O <= HWDATA_I[GBW_BIT];
      end
   end

   // pump enable and maker fields; locked fields ignore writes
   always_ff @(posedge CLK_SYS_I or posedge rst) begin
      if (rst) begin
         CHARGE_PUMP_ON_O <= 1'b0;
         host_mk          <= '{pump_mul: RST_PUMPMUL, nline: RST_NLINE, sfinv: 1'b0,
                               div: RST_DIV, tune: RST_TUNE};
      end else if (ph_wr) begin
         if (ph_addr == OFS_PUMP) begin
            CHARGE_PUMP_ON_O <= HWDATA_I[PUMP_ON_BIT];
         end
         if (!flock) begin
            if (ph_addr == OFS_PUMP) begin
               host_mk.pump_mul <= HWDATA_I[PUMP_MUL_LSB +: 2];
            end
            if (ph_addr == OFS_FRAME) begin
               host_mk.div  <= HWDATA_I[DIV_LSB +: 3];
               host_mk.tune <= HWDATA_I[TUNE_LSB +: 3];
            end
            if (ph_addr == OFS_LINE) begin
               host_mk.nline <= HWDATA_I[NLINE_LSB +: 7];
               host_mk.sfinv <= HWDATA_I[SFINV_BIT];
            end
         end
      end
   end

   // ram address register
   always_ff @(posedge CLK_SYS_I or posedge rst) begin
      if (rst) begin
         COL_ADDR_O  <= 7'h00;
         BANK_ADDR_O <= 5'h00;
      end else if (ph_wr && ph_addr == OFS_ADDR) begin
         COL_ADDR_O  <= HWDATA_I[COL_LSB +: 7];
         BANK_ADDR_O <= HWDATA_I[BANK_LSB +: 5];
      end
   end

   // otp control register
   always_ff @(posedge CLK_SYS_I or posedge rst) begin
      if (rst) begin
         calib               <= 1'b0;
         prog_req            <= 1'b0;
         OTP_VOLTAGE_APPLY_O <= 1'b0;
      end else if (ph_wr && ph_addr == OFS_OTP) begin
         calib               <= HWDATA_I[CALIB_BIT] & ~sealed;
         prog_req            <= HWDATA_I[PROG_BIT];
         OTP_VOLTAGE_APPLY_O <= HWDATA_I[OVAPPLY_BIT];
      end
   end
   logic defsel;
   always_ff @(posedge CLK_SYS_I or posedge rst) begin
      if (rst) begin
         defsel <= 1'b0;
      end else if (ph_wr && ph_addr == OFS_OTP) begin
         defsel <= HWDATA_I[DEFSEL_BIT];
      end
   end
   assign OTP_PROG_EN_O = calib & prog_req;

   assign use_mk = (defsel | flock) ? lcfg_maker_s'(OTP_MAKER_I) : host_mk;
   assign PUMP_MUL_O             = use_mk.pump_mul;
   assign PUMP_FACTOR_O          = {1'b0, use_mk.pump_mul} + 3'd4;
   assign LINE_INVERSION_COUNT_O = use_mk.nline;
   assign SUPERFRAME_INVERT_O    = use_mk.sfinv;
   assign TUNE_O                 = use_mk.tune;
   assign OSC_KHZ_O = 16'(OSC_BASE_KHZ + (OSC_BASE_KHZ * TUNE_STEP_PCT * int'(use_mk.tune)) / 100);

   // mode decode
   lcfg_mode_dec u_mode (
      .disp_on_i (disp_on),
      .allpix_i  (allpix),
      .inv_i     (inv),
      .mode_o    (MODE_O),
      .power_o   (POWER_O)
   );
   assign RAM_WR_OK_O = 1'b1;

   // oscillator tick: phase accumulator at tuned rate
   // tick rate caps at one per clock, keep OSC_KHZ_O below CLK_KHZ
   logic [15:0] osc_acc;
   logic        osc_tick;
   logic [16:0] osc_sum;
   assign osc_sum = {1'b0, osc_acc} + {1'b0, OSC_KHZ_O};
   always_ff @(posedge CLK_SYS_I or posedge rst) begin
      if (rst) begin
         osc_acc  <= 16'h0000;
         osc_tick <= 1'b0;
      end else if (!POWER_O.osc_run) begin
         osc_tick <= 1'b0;
      end else if (osc_sum >= 17'(CLK_KHZ)) begin
         osc_acc  <= 16'(osc_sum - 17'(CLK_KHZ));
         osc_tick <= 1'b1;
      end else begin
         osc_acc  <= osc_sum[15:0];
         osc_tick <= 1'b0;
      end
   end

   lcfg_frame_div u_div (
      .clk_i      (CLK_SYS_I),
      .rst_i      (rst),
      .osc_tick_i (osc_tick),
      .div_i      (use_mk.div),
      .frame_o    (FRAME_O),
      .div_act_o  ()
   );

   // read mux
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (ph_addr)
         OFS_DISP:   next_rdata = {22'h0, GREYSCALE_BW_SELECT_O, TEMP_COMP_ON_O, CLOCK_SOURCE_EXT_O, VADDR_O,
                                   RAM_BIT_ORDER_SWAP_O, BOTTOM_ROW_FLIP_O, VERTICAL_FLIP_O, allpix, inv, disp_on};
         OFS_PUMP:   next_rdata = {26'h0, use_mk.pump_mul, 3'h0, CHARGE_PUMP_ON_O};
         OFS_ADDR:   next_rdata = {19'h0, BANK_ADDR_O, 1'b0, COL_ADDR_O};
         OFS_FRAME:  next_rdata = {25'h0, use_mk.tune, 1'b0, use_mk.div};
         OFS_OTP:    next_rdata = {28'h0, prog_req, defsel, OTP_VOLTAGE_APPLY_O, calib};
         OFS_STATUS: next_rdata = {24'h0, flock, sealed, OTP_PROG_EN_O, 2'h0, MODE_O};
         OFS_LINE:   next_rdata = {24'h0, use_mk.sfinv, use_mk.nline};
         default:    next_rdata = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge CLK_SYS_I or posedge rst) begin
      if (rst) begin
         HRDATA_O <= 32'h0000_0000;
      end else if (ph_rd) begin
         // taken in the wait cycle, held until the next read
         HRDATA_O <= next_rdata;
      end
   end

   // checks
   AST_PDOWN: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      (!disp_on && allpix) |-> (MODE_O == MODE_PDOWN && !POWER_O.osc_run && !POWER_O.hv_on))
      else $error("power-down decode wrong");
   AST_OFF: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      (!disp_on && !allpix) |-> (POWER_O.rows_gnd && POWER_O.osc_run && POWER_O.hv_on))
      else $error("display-off decode wrong");
   AST_ALLON: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      (disp_on && allpix && inv) |-> MODE_O == MODE_ALLON)
      else $error("all-on priority wrong");
   AST_INV: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      (disp_on && !allpix && inv) |-> (MODE_O == MODE_INVERSE && !POWER_O.rows_gnd))
      else $error("inverse decode wrong");
   AST_OTP_LOCKED_FLAG: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      sealed && $stable(sealed) |=> !$rose(calib))
      else $error("calibration entered while sealed");
   AST_PROG: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      OTP_PROG_EN_O |-> calib)
      else $error("programming outside calibration");
   AST_LOCK: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      flock && $stable(flock) |=> $stable(host_mk))
      else $error("locked field changed");
   AST_OTPSEL: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      (defsel || flock) |-> (LINE_INVERSION_COUNT_O == OTP_MAKER_I[13:7] && TUNE_O == OTP_MAKER_I[2:0]))
      else $error("otp data not in use");
   AST_PUMP: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      PUMP_FACTOR_O[2] && PUMP_FACTOR_O[1:0] == PUMP_MUL_O)
      else $error("pump factor wrong");
   AST_COL: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      (ph_wr && ph_addr == OFS_ADDR) |=> COL_ADDR_O == $past(HWDATA_I[6:0]))
      else $error("column address not stored");
   AST_RDCOL: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      (acc && !HWRITE_I && HADDR_I[7:0] == OFS_ADDR) |=>
         !HREADYOUT_O ##1 (HREADYOUT_O && HRDATA_O[6:0] == COL_ADDR_O))
      else $error("column read-back wrong");
   AST_OSCSTOP: assert property (@(posedge CLK_SYS_I) disable iff (rst)
      !POWER_O.osc_run |=> !osc_tick)
      else $error("oscillator ticks in power-down");
   AST_RST: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I)
      $fell(clear_req) |-> (MODE_O == MODE_PDOWN && TEMP_COMP_ON_O && (flock || TUNE_O == RST_TUNE)))
      else $error("reset state wrong");
   COV_NORMAL: cover property (@(posedge CLK_SYS_I) MODE_O == MODE_NORMAL);
   COV_INV:    cover property (@(posedge CLK_SYS_I) MODE_O == MODE_INVERSE);
   COV_PDOWN:  cover property (@(posedge CLK_SYS_I) MODE_O == MODE_PDOWN);
   COV_ALLON:  cover property (@(posedge CLK_SYS_I) MODE_O == MODE_ALLON);
   COV_FRAME:  cover property (@(posedge CLK_SYS_I) FRAME_O);
endmodule

// [bench/lcfg_host.sv]
`timescale 1ns/100ps
module lcfg_host
   import lcfg_pkg::*;
(
   input  wire logic        clk_i,    // bus clock
   input  wire logic        hready_i, // slave ready
   input  wire logic [31:0] hrdata_i, // read data
   output logic [1:0]       htrans_o, // transfer type
   output logic             hsel_o,   // slave select
   output logic [31:0]      haddr_o,  // byte address
   output logic             hwrite_o, // write flag
   output logic [2:0]       hsize_o,  // transfer size
   output logic [31:0]      hwdata_o  // write data
);
   // idle bus from time zero
   initial begin
      htrans_o = 2'h0;
      hsel_o   = 1'b0;
      haddr_o  = 32'h0000_0000;
      hwrite_o = 1'b0;
      hsize_o  = 3'h2;
      hwdata_o = 32'h0000_0000;
   end

   // single word transfer, held until ready
   // no soft reset
   task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
      htrans_o <= 2'h2;
      hsel_o   <= 1'b1;
      haddr_o  <= {24'h00_0000, adr};
      hwrite_o <= wr;
      hsize_o  <= 3'h2;
      do @(posedge clk_i); while (hready_i !== 1'b1);
      htrans_o <= 2'h0;
      hsel_o   <= 1'b0;
      hwdata_o <= wd;
      do @(posedge clk_i); while (hready_i !== 1'b1);
      rd = hrdata_i;
      // released data must not look stale
      hwdata_o <= ~wd;
      // let the landing edge settle before the caller looks
      #1;
   endtask
endmodule

// [bench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
   import lcfg_pkg::*;
   localparam int CLKK = 500;           // shortened clock figure
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        clr_n = 1'b0;
   logic        otp_locked_flag = 1'b0;
   logic        flock = 1'b0;
   logic [15:0] maker = 16'h0000;
   logic [1:0]  htrans, pmul;
   logic        hsel, hwrite, hready, hresp, ramok, progen, frame, pon, bswap, vaddr;
   logic        vflip, brflip, clkext, tcomp, ovap, gbw, sfinv;
   logic [2:0]  hsize, pfac, tune;
   logic [31:0] haddr, hwdata, hrdata;
   logic [6:0]  col, nline;
   logic [4:0]  bank;
   logic [15:0] osck;
   lcfg_mode_e  mode;
   lcfg_power_s power;
   int          miscompares = 0;
   int          total_checks = 0;
   int          rt[8] = '{2448, 3265, 4082, 4896, 5714, 7340, 8968, 11428};

   lcfg_top #(.CLK_KHZ(CLKK)) u_lcfg_top (
      .CLK_SYS_I(clk), .SYS_RST_I(rst), .HARD_CLEAR_N_I(clr_n), .OTP_LOCKED_FLAG_I(otp_locked_flag),
      .OTP_FACTORY_LOCK_I(flock), .OTP_MAKER_I(maker), .HTRANS_I(htrans), .HSEL_I(hsel), .HADDR_I(haddr),
      .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .MODE_O(mode), .POWER_O(power), .RAM_WR_OK_O(ramok),
      .OTP_PROG_EN_O(progen), .FRAME_O(frame), .PUMP_MUL_O(pmul), .PUMP_FACTOR_O(pfac),
      .CHARGE_PUMP_ON_O(pon), .RAM_BIT_ORDER_SWAP_O(bswap), .VADDR_O(vaddr), .VERTICAL_FLIP_O(vflip),
      .BOTTOM_ROW_FLIP_O(brflip), .CLOCK_SOURCE_EXT_O(clkext), .TEMP_COMP_ON_O(tcomp),
      .OTP_VOLTAGE_APPLY_O(ovap), .GREYSCALE_BW_SELECT_O(gbw), .COL_ADDR_O(col), .BANK_ADDR_O(bank),
      .LINE_INVERSION_COUNT_O(nline), .SUPERFRAME_INVERT_O(sfinv), .TUNE_O(tune), .OSC_KHZ_O(osck));

   lcfg_host u_lcfg_host (
      .clk_i(clk), .hready_i(hready), .hrdata_i(hrdata), .htrans_o(htrans), .hsel_o(hsel),
      .haddr_o(haddr), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

   // 10 MHz system clock
   always #50 clk = ~clk;

   // comparison helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic near(input int got, input int exp, input string msg);
      total_checks++;
      if (got > exp + exp / 50 || got < exp - exp / 50) begin
         miscompares++;
         $display("Error at %0t: %s got %0d exp %0d", $time, msg, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      u_lcfg_host.xfer(1'b1, a, d, r);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string msg);
      logic [31:0] r;
      u_lcfg_host.xfer(1'b0, a, 32'h0000_0000, r);
      chk(r, e, msg);
   endtask
   // frame length in clocks for a code and tune
   function automatic int fexp(input int c, input int t);
      return rt[c] * CLKK / (400 + 16 * t);
   endfunction
   // expected {power, mode} for {allpix, inv, on}
   function automatic logic [5:0] emode(input logic [2:0] b);
      if (!b[0]) return b[2] ? {3'b100, MODE_PDOWN} : {3'b111, MODE_OFF};
      if (b[2]) return {3'b011, MODE_ALLON};
      return b[1] ? {3'b011, MODE_INVERSE} : {3'b011, MODE_NORMAL};
   endfunction
   task automatic gap(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (frame !== 1'b1);
   endtask
   task automatic dflt();
      chk({power, mode}, {3'b100, MODE_PDOWN}, "reset mode");
      chk({pmul, pon, bswap, vaddr, vflip, brflip, clkext, ovap, gbw, tcomp}, 32'h1, "reset bits");
      chk({nline, tune, osck}, {RST_NLINE, RST_TUNE, 16'd496}, "reset line tune");
      rdc(OFS_DISP, 32'h0000_0104, "disp reset");
      rdc(OFS_FRAME, 32'h0000_0061, "frame reset");
      rdc(OFS_ADDR, 32'h0000_0000, "addr reset");
      rdc(OFS_OTP, 32'h0000_0000, "otp reset");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      summarize();
   end

   initial begin
      logic [31:0] d, p, a;
      int          n, prev, cl[2];
      cl = '{0, 7};
      void'($urandom(75502));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      clr_n <= 1'b1;
      repeat (6) @(posedge clk);
      chk({hready, hresp}, 32'h2, "bus answer");
      dflt();
      $display("test reset done");
      wr(OFS_DISP, 32'h0000_0101);
      gap(n);
      gap(n);
      near(n, fexp(1, 6), "default frame");
      wr(OFS_FRAME, 32'h0000_0001);
      gap(n);
      gap(n);
      near(n, fexp(1, 0), "frame code 1");
      prev = 1;
      foreach (cl[i]) begin
         wr(OFS_FRAME, cl[i]);
         gap(n);
         near(n + 2, fexp(prev, 0), "frame kept to boundary");
         gap(n);
         near(n, fexp(cl[i], 0), "frame new code");
         prev = cl[i];
      end
      $display("test frame done");
      for (int m = 0; m < 8; m++) begin
         wr(OFS_DISP, m);
         chk({power, mode}, emode(3'(m)), "mode table");
         chk(ramok, 1'b1, "ram writes open");
         rdc(OFS_STATUS, 32'(emode(3'(m)) & 6'h07), "status mode");
      end
      $display("test mode done");
      for (int i = 0; i < 16; i++) begin
         d = (i == 0) ? 32'hFFFF_FFFF : $urandom;
         p = (i == 1) ? 32'h0000_0000 : $urandom;
         a = (i == 0) ? 32'hFFFF_FFFF : $urandom;
         wr(OFS_DISP, d);
         wr(OFS_PUMP, p);
         wr(OFS_ADDR, a);
         chk({gbw, tcomp, clkext, vaddr, bswap, brflip, vflip}, d[9:3], "disp bits");
         chk({pfac, pmul, pon}, {p[5:4] + 3'd4, p[5:4], p[0]}, "pump");
         chk({bank, col}, {a[12:8], a[6:0]}, "ram address");
         rdc(OFS_DISP, d & 32'h0000_03FF, "disp readback");
      end
      $display("test fields done");
      otp_locked_flag <= 1'b1;
      wr(OFS_OTP, 32'h0000_0009);
      chk(progen, 1'b0, "sealed entry");
      rdc(OFS_OTP, 32'h0000_0008, "sealed calib");
      otp_locked_flag <= 1'b0;
      wr(OFS_OTP, 32'h0000_0009);
      chk(progen, 1'b1, "prog in calib");
      wr(OFS_OTP, 32'h0000_000A);
      chk({progen, ovap}, 32'h1, "exit calib, offset on");
      maker <= 16'($urandom);
      wr(OFS_LINE, 32'h0000_00AA);
      wr(OFS_OTP, 32'h0000_0004);
      chk({nline, sfinv, tune}, {maker[13:7], maker[6], maker[2:0]}, "otp data used");
      wr(OFS_OTP, 32'h0000_0000);
      chk({nline, sfinv, tune}, {7'h2A, 1'b1, 3'h0}, "host data used");
      flock <= 1'b1;
      wr(OFS_LINE, 32'h0000_0055);
      rdc(OFS_LINE, {24'h0, maker[6], maker[13:7]}, "locked uses otp");
      flock <= 1'b0;
      rdc(OFS_LINE, 32'h0000_00AA, "locked write ignored");
      $display("test otp done");
      wr(8'h40, 32'hFFFF_FFFF);
      rdc(8'h40, 32'h0000_0000, "unmapped");
      wr(OFS_DISP, 32'h0000_0001);
      clr_n <= 1'b0;
      repeat (5) @(posedge clk);
      clr_n <= 1'b1;
      repeat (6) @(posedge clk);
      dflt();
      $display("test pin clear done");
      summarize();
   end
endmodule
